// ===== verilog/pim_pixel_pipeline.v
// Pixel input multiplexer, serialiser and colour source selection.
`timescale 1ns/1ns
`default_nettype none
`include "pim_defs.vh"

module pim_pixel_pipeline (
    input wire aclk,
    input wire aresetn,
    input wire pixel_load_strobe_n,
    input wire [44:0] pixel_inputs,
    input wire [19:0] overlay_inputs,
    input wire [4:0] overlay_enable_input,
    input wire sync_in_n,
    input wire blank_in_n,
    input wire [1:0] cursor_plane_codes,
    input wire crosshair_window_in,
    output reg [1:0] color_source,
    output reg [8:0] color_index,
    output reg sync_out_n,
    output reg blank_out_n,
    output reg transfer_locked,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    reg [`PIM_CTRL_W-1:0] ctrl_r;
    reg [8:0] pix_rmask_r;
    reg [8:0] pix_bmask_r;
    reg [7:0] ovl_mask_r;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_got_r;
    reg w_got_r;
    reg blink_off_r;
    reg [31:0] rdata_nxt;
    reg [1:0] rresp_nxt;

    wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] mask;
        begin
            merge = (old & ~mask) | (data & mask);
        end
    endfunction

    wire [31:0] ctrl_m = merge({{(32-`PIM_CTRL_W){1'b0}}, ctrl_r}, wdata_r, wmask);
    wire [31:0] prm_m = merge({23'h0, pix_rmask_r}, wdata_r, wmask);
    wire [31:0] pbm_m = merge({23'h0, pix_bmask_r}, wdata_r, wmask);
    wire [31:0] ovm_m = merge({24'h0, ovl_mask_r}, wdata_r, wmask);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIM_RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            ctrl_r <= `PIM_CTRL_RESET;
            pix_rmask_r <= `PIM_PIX_RMASK_RESET;
            pix_bmask_r <= `PIM_PIX_BMASK_RESET;
            ovl_mask_r <= `PIM_OVL_MASK_RESET;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PIM_RESP_OKAY;
                if (awaddr_r == `PIM_ADDR_CTRL) begin
                    ctrl_r <= ctrl_m[`PIM_CTRL_W-1:0];
                end else if (awaddr_r == `PIM_ADDR_PIX_RMASK) begin
                    pix_rmask_r <= prm_m[8:0];
                end else if (awaddr_r == `PIM_ADDR_PIX_BMASK) begin
                    pix_bmask_r <= pbm_m[8:0];
                end else if (awaddr_r == `PIM_ADDR_OVL_MASK) begin
                    ovl_mask_r <= ovm_m[7:0];
                end else begin
                    s_axi_bresp <= `PIM_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @* begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `PIM_RESP_OKAY;
        if (s_axi_araddr == `PIM_ADDR_CTRL) begin
            rdata_nxt[`PIM_CTRL_W-1:0] = ctrl_r;
        end else if (s_axi_araddr == `PIM_ADDR_PIX_RMASK) begin
            rdata_nxt[8:0] = pix_rmask_r;
        end else if (s_axi_araddr == `PIM_ADDR_PIX_BMASK) begin
            rdata_nxt[8:0] = pix_bmask_r;
        end else if (s_axi_araddr == `PIM_ADDR_OVL_MASK) begin
            rdata_nxt[7:0] = ovl_mask_r;
        end else if (s_axi_araddr == `PIM_ADDR_STATUS) begin
            rdata_nxt[`PIM_STAT_LOCKED] = transfer_locked;
            rdata_nxt[`PIM_STAT_BLINK] = blink_off_r;
        end else begin
            rresp_nxt = `PIM_RESP_SLVERR;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PIM_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire [1:0] ratio = ctrl_r[`PIM_CTRL_RATIO];
    wire [1:0] bpp = ctrl_r[`PIM_CTRL_BPP];
    wire [2:0] pan = (ctrl_r[`PIM_CTRL_PAN] > `PIM_PAN_MAX) ? `PIM_PAN_MAX : ctrl_r[`PIM_CTRL_PAN];
    wire [2:0] group_n = (ratio == `PIM_RATIO_4) ? `PIM_GROUP_4 :
                         (ratio == `PIM_RATIO_5) ? `PIM_GROUP_5 : `PIM_GROUP_1;
    wire [2:0] group_m1 = group_n - 3'h1;
    wire one_to_one = (ratio == `PIM_RATIO_1);
    wire [2:0] subs_m1 = (bpp == `PIM_BPP_1) ? 3'h7 : (bpp == `PIM_BPP_2) ? 3'h3 :
                         (bpp == `PIM_BPP_4) ? 3'h1 : 3'h0;
    // Block modes assume unity zoom, so the word span is the sub-pixel count there and the zoom count in 8 bpp.
    wire [3:0] span_m1 = (bpp == `PIM_BPP_8) ? ctrl_r[`PIM_CTRL_ZOOM] : {1'b0, subs_m1};

    // ----------------------------------------
    // Pin synchronisers and load strobe edge
    // ----------------------------------------
    reg ld_s1_r, ld_s2_r, ld_s3_r;
    reg [71:0] din_s1_r, din_s2_r;
    wire [71:0] din_pin = {blank_in_n, sync_in_n, overlay_enable_input, overlay_inputs, pixel_inputs};

    always @(posedge aclk) begin
        if (!aresetn) begin
            ld_s1_r <= 1'b1;
            ld_s2_r <= 1'b1;
            ld_s3_r <= 1'b1;
            din_s1_r <= {72{1'b0}};
            din_s2_r <= {72{1'b0}};
        end else begin
            ld_s1_r <= pixel_load_strobe_n;
            ld_s2_r <= ld_s1_r;
            ld_s3_r <= ld_s2_r;
            din_s1_r <= din_pin;
            din_s2_r <= din_s1_r;
        end
    end

    // Two sync stages put the internal load two clocks behind the strobe rise.
    wire load_p = ld_s2_r & ~ld_s3_r;
    // In 1:1 the strobe itself paces the pixels; the clock only samples it.
    wire pix_adv = one_to_one ? load_p : 1'b1;

    // ----------------------------------------
    // Lock monitor
    // ----------------------------------------
    reg [3:0] gap_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            gap_r <= 4'h0;
            transfer_locked <= 1'b0;
        end else if (load_p) begin
            gap_r <= 4'h0;
            if (one_to_one) begin
                transfer_locked <= ({28'h0, gap_r} >= (`PIM_LD11_MIN_CYCLES - 1));
            end else begin
                transfer_locked <= (gap_r == {1'b0, group_m1});
            end
        end else begin
            if (gap_r != 4'hF) begin
                gap_r <= gap_r + 4'h1;
            end
            if (!one_to_one && gap_r >= {1'b0, group_n}) begin
                transfer_locked <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Second latch and serialising counters
    // ----------------------------------------
    reg [71:0] hold_r;
    reg [3:0] ld_cnt_r;
    reg [3:0] rep_r;
    reg [2:0] sub_r;
    reg [2:0] pidx_r;
    reg [2:0] oph_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            hold_r <= {72{1'b0}};
            ld_cnt_r <= 4'h0;
            rep_r <= 4'h0;
            sub_r <= 3'h0;
            pidx_r <= 3'h0;
            oph_r <= 3'h0;
        end else begin
            if (load_p) begin
                hold_r <= din_s2_r;
                ld_cnt_r <= (ld_cnt_r >= span_m1) ? 4'h0 : ld_cnt_r + 4'h1;
                oph_r <= 3'h0;
            end else if (!one_to_one && oph_r != group_m1) begin
                oph_r <= oph_r + 3'h1;
            end
            // Only the strobe at the head of a word span (ld_cnt_r zero) restarts the pixel order.
            if (load_p && ld_cnt_r == 4'h0) begin
                rep_r <= 4'h0;
                sub_r <= 3'h0;
                pidx_r <= 3'h0;
            end else if (pix_adv) begin
                if (rep_r < ctrl_r[`PIM_CTRL_ZOOM] && bpp == `PIM_BPP_8) begin
                    rep_r <= rep_r + 4'h1;
                end else begin
                    rep_r <= 4'h0;
                    if (sub_r < subs_m1) begin
                        sub_r <= sub_r + 3'h1;
                    end else begin
                        sub_r <= 3'h0;
                        pidx_r <= (pidx_r >= group_m1) ? 3'h0 : pidx_r + 3'h1;
                    end
                end
            end
        end
    end

    wire [8:0] pix_word = hold_r[pidx_r * 9 +: 9];
    wire [3:0] ovl_word = hold_r[45 + oph_r * 4 +: 4];
    wire ole_word = hold_r[65 + oph_r];
    wire [8:0] pix_um;
    wire [3:0] ovl_um;

    pim_unpack_mask u_unpack (
        .pix_word(pix_word),
        .ovl_word(ovl_word),
        .sub_idx(sub_r),
        .bpp_sel(bpp),
        .pix_rmask(pix_rmask_r),
        .pix_bmask(pix_bmask_r),
        .ovl_rmask(ovl_mask_r[`PIM_OVL_RMASK]),
        .ovl_bmask(ovl_mask_r[`PIM_OVL_BMASK]),
        .blink_off(blink_off_r),
        .pix_out(pix_um),
        .ovl_out(ovl_um)
    );

    // ----------------------------------------
    // Vertical retrace and blink phase
    // ----------------------------------------
    reg [8:0] ret_cnt_r;
    reg [6:0] frame_r;
    wire [6:0] frame_nxt = frame_r + 7'h1;
    wire ret_p = load_p & ~din_s2_r[71] & (ret_cnt_r == `PIM_RETRACE_LOADS);
    reg blink_off_nxt;

    always @* begin
        case (ctrl_r[`PIM_CTRL_BLINK])
            2'h0: blink_off_nxt = frame_nxt[`PIM_BLINK_FAST_BIT];
            2'h1: blink_off_nxt = frame_nxt[`PIM_BLINK_MID_BIT];
            2'h2: blink_off_nxt = frame_nxt[`PIM_BLINK_SLOW_BIT];
            default: blink_off_nxt = frame_nxt[`PIM_BLINK_SLOW_BIT] & frame_nxt[`PIM_BLINK_MID_BIT];
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ret_cnt_r <= 9'h000;
            frame_r <= 7'h00;
            blink_off_r <= 1'b0;
        end else begin
            if (load_p) begin
                if (din_s2_r[71]) begin
                    ret_cnt_r <= 9'h000;
                end else if (ret_cnt_r <= `PIM_RETRACE_LOADS) begin
                    ret_cnt_r <= ret_cnt_r + 9'h001;
                end
            end
            // Blink only flips inside retrace so no colour changes mid-screen.
            if (ret_p) begin
                frame_r <= frame_nxt;
                blink_off_r <= blink_off_nxt;
            end
        end
    end

    // ----------------------------------------
    // Pan delay line
    // ----------------------------------------
    reg [8:0] pix_dly_r [0:4];
    reg [6:0] side_dly_r [0:4];

    always @(posedge aclk) begin
        if (!aresetn) begin
            pix_dly_r[0] <= 9'h000;
            side_dly_r[0] <= 7'h60;
        end else begin
            pix_dly_r[0] <= pix_um;
            side_dly_r[0] <= {hold_r[71], hold_r[70], ole_word, ovl_um};
        end
    end

    genvar k;
    generate
        for (k = 1; k < 5; k = k + 1) begin : g_dly
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pix_dly_r[k] <= 9'h000;
                    side_dly_r[k] <= 7'h60;
                end else begin
                    pix_dly_r[k] <= pix_dly_r[k-1];
                    side_dly_r[k] <= side_dly_r[k-1];
                end
            end
        end
    endgenerate

    // Pixels leave early by the pan count; overlays and sync keep full depth.
    wire [8:0] pix_p = pix_dly_r[`PIM_PAN_MAX - pan];
    wire [6:0] side_p = side_dly_r[`PIM_PAN_MAX];

    // ----------------------------------------
    // Colour source selection
    // ----------------------------------------
    wire [3:0] ovl_p = side_p[3:0];
    wire ole_p = side_p[4];
    // Cursor codes and window are taken unpanned so the cursor stays put.
    wire bank = pix_p[8] | (ctrl_r[`PIM_CTRL_WIN_BANK] & crosshair_window_in);
    wire [8:0] pal_idx = {bank, pix_p[7:0]};
    reg [1:0] src_nxt;
    reg [8:0] idx_nxt;

    always @* begin
        src_nxt = `PIM_SEL_PALETTE;
        idx_nxt = pal_idx;
        if (cursor_plane_codes != 2'h0) begin
            src_nxt = `PIM_SEL_CURSOR;
            idx_nxt = {7'h00, cursor_plane_codes};
        end else if (ctrl_r[`PIM_CTRL_XSTYLE]) begin
            if (ole_p) begin
                src_nxt = `PIM_SEL_OVERLAY;
                idx_nxt = {5'h00, ovl_p};
            end
        end else if (ovl_p != 4'h0) begin
            src_nxt = `PIM_SEL_OVERLAY;
            idx_nxt = {5'h00, ovl_p};
        end else if (ctrl_r[`PIM_CTRL_UNDERLAY]) begin
            if (ole_p && pal_idx == 9'h000) begin
                src_nxt = `PIM_SEL_OVERLAY;
                idx_nxt = 9'h000;
            end
        end else if (ctrl_r[`PIM_CTRL_OVL_ZERO]) begin
            src_nxt = `PIM_SEL_OVERLAY;
            idx_nxt = 9'h000;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            color_source <= `PIM_SEL_PALETTE;
            color_index <= 9'h000;
            sync_out_n <= 1'b1;
            blank_out_n <= 1'b1;
        end else begin
            color_source <= src_nxt;
            color_index <= idx_nxt;
            sync_out_n <= side_p[5];
            blank_out_n <= side_p[6];
        end
    end

endmodule // pim_pixel_pipeline
`default_nettype wire

// ===== pkg/pim_defs.vh
// Constants shared by the pixel input pipeline files.
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PIM_ADDR_CTRL 8'h00
`define PIM_ADDR_PIX_RMASK 8'h04
`define PIM_ADDR_PIX_BMASK 8'h08
`define PIM_ADDR_OVL_MASK 8'h0C
`define PIM_ADDR_STATUS 8'h10

// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define PIM_CTRL_W 17
`define PIM_CTRL_RATIO 1:0
`define PIM_CTRL_PAN 4:2
`define PIM_CTRL_ZOOM 8:5
`define PIM_CTRL_BPP 10:9
`define PIM_CTRL_UNDERLAY 11
`define PIM_CTRL_XSTYLE 12
`define PIM_CTRL_OVL_ZERO 13
`define PIM_CTRL_WIN_BANK 14
`define PIM_CTRL_BLINK 16:15
`define PIM_CTRL_RESET 17'h00001
`define PIM_PIX_RMASK_RESET 9'h1FF
`define PIM_PIX_BMASK_RESET 9'h000
`define PIM_OVL_MASK_RESET 8'h0F
`define PIM_OVL_RMASK 3:0
`define PIM_OVL_BMASK 7:4
`define PIM_STAT_LOCKED 0
`define PIM_STAT_BLINK 1

// ----------------------------------------
// Modes and encodings
// ----------------------------------------
`define PIM_RATIO_1 2'h0
`define PIM_RATIO_4 2'h1
`define PIM_RATIO_5 2'h2
`define PIM_GROUP_1 3'h1
`define PIM_GROUP_4 3'h4
`define PIM_GROUP_5 3'h5
`define PIM_BPP_8 2'h0
`define PIM_BPP_4 2'h1
`define PIM_BPP_2 2'h2
`define PIM_BPP_1 2'h3
`define PIM_FIELD_4 8'h0F
`define PIM_FIELD_2 8'h03
`define PIM_FIELD_1 8'h01
`define PIM_SEL_PALETTE 2'h0
`define PIM_SEL_OVERLAY 2'h1
`define PIM_SEL_CURSOR 2'h2
`define PIM_RESP_OKAY 2'h0
`define PIM_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define PIM_PAN_MAX 3'h4
`define PIM_RETRACE_LOADS 9'h100
`define PIM_ACLK_MHZ 250
`define PIM_LD11_MAX_MHZ 50
`define PIM_LD11_MIN_CYCLES ((`PIM_ACLK_MHZ + `PIM_LD11_MAX_MHZ - 1) / `PIM_LD11_MAX_MHZ)
`define PIM_BLINK_SLOW_BIT 5
`define PIM_BLINK_MID_BIT 4
`define PIM_BLINK_FAST_BIT 3

`endif

// ===== verilog/pim_unpack_mask.v
// Block-mode unpacking plus read and blink masking of one pixel and overlay.
`timescale 1ns/1ns
`default_nettype none
`include "pim_defs.vh"

module pim_unpack_mask (
    input wire [8:0] pix_word,
    input wire [3:0] ovl_word,
    input wire [2:0] sub_idx,
    input wire [1:0] bpp_sel,
    input wire [8:0] pix_rmask,
    input wire [8:0] pix_bmask,
    input wire [3:0] ovl_rmask,
    input wire [3:0] ovl_bmask,
    input wire blink_off,
    output wire [8:0] pix_out,
    output wire [3:0] ovl_out
);

    reg [7:0] low_r;
    wire [12:0] raw_w;
    wire [12:0] rmask_w;
    wire [12:0] bmask_w;
    wire [12:0] out_w;

    // ----------------------------------------
    // Unpacking, most significant field first
    // ----------------------------------------
    always @* begin
        case (bpp_sel)
            `PIM_BPP_4: low_r = (pix_word[7:0] >> {~sub_idx[0], 2'b00}) & `PIM_FIELD_4;
            `PIM_BPP_2: low_r = (pix_word[7:0] >> {~sub_idx[1:0], 1'b0}) & `PIM_FIELD_2;
            `PIM_BPP_1: low_r = (pix_word[7:0] >> (~sub_idx)) & `PIM_FIELD_1;
            default: low_r = pix_word[7:0];
        endcase
    end

    // The top pixel bit bypasses unpacking and stays the bank bit.
    assign raw_w = {ovl_word, pix_word[8], low_r};
    assign rmask_w = {ovl_rmask, pix_rmask};
    assign bmask_w = {ovl_bmask, pix_bmask};

    // ----------------------------------------
    // Per-bit read and blink masks
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 13; i = i + 1) begin : g_mask
            assign out_w[i] = raw_w[i] & rmask_w[i] & ~(bmask_w[i] & blink_off);
        end
    endgenerate

    assign pix_out = out_w[8:0];
    assign ovl_out = out_w[12:9];

endmodule // pim_unpack_mask
`default_nettype wire

// ===== verif/pim_pixel_pipeline_props.sv
// Port checker for the pixel input pipeline.
`timescale 1ns/1ns
`default_nettype none
module pim_pixel_pipeline_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pixel_load_strobe_n,
    input wire logic [1:0] cursor_plane_codes,
    input wire logic [1:0] color_source,
    input wire logic [8:0] color_index,
    input wire logic transfer_locked,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Clocks since the strobe pin rose; saturates so a long gap never looks recent.
    logic [3:0] since_r = 4'hF;
    always @(posedge aclk) begin
        since_r <= $rose(pixel_load_strobe_n) ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
    end
    a_cursor_wins: assert property (cursor_plane_codes != 2'h0 |=> color_source == 2'h2)
        else $error("cursor code did not win");
    a_cursor_colour: assert property (cursor_plane_codes != 2'h0 |=> color_index == {7'h00, $past(cursor_plane_codes)})
        else $error("cursor colour index wrong");
    a_no_cursor: assert property (cursor_plane_codes == 2'h0 |=> color_source != 2'h2)
        else $error("cursor shown without a code");
    a_lock_after_load: assert property ($rose(transfer_locked) |-> since_r <= 4'h6)
        else $error("lock rose far from a strobe");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken before answer");
endmodule // pim_pixel_pipeline_props
bind pim_pixel_pipeline pim_pixel_pipeline_props u_props (.*);
`default_nettype wire

// ===== verif/pim_fb_model.sv
// Frame buffer and video timing model feeding the pixel pipeline.
`timescale 1ns/1ns
`default_nettype none
module pim_fb_model (
    input wire logic aclk,
    input wire logic [4:0] period,
    input wire logic [44:0] word,
    input wire logic [19:0] ovl,
    input wire logic sb_n,
    output logic pixel_load_strobe_n,
    output logic [44:0] pixel_inputs,
    output logic [19:0] overlay_inputs,
    output logic [4:0] overlay_enable_input,
    output logic sync_in_n,
    output logic blank_in_n
);
    logic [4:0] cnt_r = 5'h00;
    initial begin
        pixel_load_strobe_n = 1'b1;
        pixel_inputs = '0;
        overlay_inputs = '0;
    end
    // One strobe rise per period; data moves half a period from the rise so it is settled there.
    always @(posedge aclk) begin
        cnt_r <= (cnt_r + 5'h01 >= period) ? 5'h00 : cnt_r + 5'h01;
        pixel_load_strobe_n <= (cnt_r >= (period >> 1));
        if (cnt_r == 5'h00) begin
            pixel_inputs <= word;
            overlay_inputs <= ovl;
        end
    end
    // No panning is used, so sync and blank owe no extra delay.
    assign overlay_enable_input = 5'h00;
    assign sync_in_n = sb_n;
    assign blank_in_n = sb_n;
endmodule // pim_fb_model
`default_nettype wire

// ===== verif/pim_pixel_pipeline_bench.sv
// Self-checking bench for the pixel input pipeline.
`timescale 1ns/1ns
`default_nettype none
module pim_pixel_pipeline_bench;
    logic aclk, aresetn, pixel_load_strobe_n, sync_in_n, blank_in_n, crosshair_window_in, sb_n;
    logic sync_out_n, blank_out_n, transfer_locked;
    logic [4:0] period, overlay_enable_input;
    logic [44:0] word, pixel_inputs;
    logic [19:0] ovl, overlay_inputs;
    logic [1:0] cursor_plane_codes, color_source, s_axi_bresp, s_axi_rresp;
    logic [8:0] color_index;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_mismatch = 0;
    int checks = 0;
    pim_pixel_pipeline u_dut (.*);
    pim_fb_model u_fb (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic to(input int n, input int lim);
        if (n == lim) begin
            n_mismatch++;
            $display("wrong value wait expected done seen timeout");
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        to(n, 40);
        chk("bresp", 32'(e), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        to(n, 40);
    endtask
    task automatic wt(input logic [1:0] s, input logic [8:0] v);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if (color_source === s && color_index === v) break;
        end
        checks++;
        to(n, 300);
    endtask
    task automatic s_regs();
        logic [31:0] e [4] = '{32'h1, 32'h1FF, 32'h0, 32'hF};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), d, r);
            chk("reset value", e[i], d);
        end
        rd(8'h14, d, r);
        chk("unmapped resp", 32'h2, 32'(r));
        wr(8'h10, 32'h3, 2'h2);
    endtask
    // Wrong spacing must drop the lock and a correct ratio must win it back.
    task automatic s_lock();
        logic [1:0] rt [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
        logic [4:0] pr [5] = '{5'h04, 5'h05, 5'h05, 5'h14, 5'h04};
        logic ex [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, 32'(rt[i]), 2'h0);
            period <= pr[i];
            repeat (120) @(posedge aclk);
            chk("locked", 32'(ex[i]), 32'(transfer_locked));
        end
    endtask
    task automatic s_pix(input logic [8:0] m, input logic [8:0] o, input int z);
        logic [44:0] w;
        w = {9'h000, 9'h044, 9'h1F3, 9'h022, 9'h101};
        word <= w;
        // Let a mode change settle, then catch pixel A on its first copy after D.
        repeat (20) @(posedge aclk);
        wt(2'h0, (w[35:27] & m) | o);
        wt(2'h0, (w[8:0] & m) | o);
        for (int k = 1; k < 4 * z; k++) begin
            @(posedge aclk);
            chk("pixel", 32'((w[k / z * 9 +: 9] & m) | o), 32'(color_index));
        end
    endtask
    task automatic s_cursor();
        for (int c = 1; c < 4; c++) begin
            cursor_plane_codes <= 2'(c);
            repeat (2) @(posedge aclk);
            chk("cursor source", 32'h2, 32'(color_source));
            chk("cursor colour", 32'(c), 32'(color_index));
        end
        cursor_plane_codes <= 2'h0;
    endtask
    task automatic s_ovl();
        chk("sync blank", 32'h3, 32'({sync_out_n, blank_out_n}));
        sb_n <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("sync blank", 32'h0, 32'({sync_out_n, blank_out_n}));
        sb_n <= 1'b1;
        ovl <= 20'h55555;
        wt(2'h1, 9'h005);
        ovl <= 20'h00000;
        wr(8'h00, 32'h2001, 2'h0);
        wt(2'h1, 9'h000);
    endtask
    initial begin
        aresetn = 1'b0;
        {period, word, ovl, cursor_plane_codes, crosshair_window_in, sb_n} = {5'h04, 68'h0, 1'b1};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {52'h0, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_lock();
        s_pix(9'h1FF, 9'h000, 1);
        wr(8'h04, 32'hFF, 2'h0);
        s_pix(9'h0FF, 9'h000, 1);
        wr(8'h00, 32'h4001, 2'h0);
        crosshair_window_in <= 1'b1;
        s_pix(9'h0FF, 9'h100, 1);
        s_cursor();
        s_ovl();
        wr(8'h00, 32'h21, 2'h0);
        s_pix(9'h0FF, 9'h000, 2);
        end_sim();
    end
endmodule // pim_pixel_pipeline_bench
`default_nettype wire
